// ---- eas_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants of the event/action sequencer
// ----------------------------------------------------------------------------
package eas_pkg;
  // Sequence size
  localparam int MAX_PAIRS = 20;
  localparam int STEP_W = 5;
  localparam logic [4:0] STEP_RESET = 5'h00;
  // Boolean sources
  localparam int STATUS_N = 8;
  localparam int CMP_N = 4;
  localparam int RULE_N = 4;
  localparam int VAL_W = 16;
  localparam int SEL_W = 4;
  // Rule inputs: status bits, comparators, last-event flag
  localparam int RULE_SRC_N = STATUS_N + CMP_N + 1;
  // Event inputs: status bits, comparators, rules
  localparam int EVT_SRC_N = STATUS_N + CMP_N + RULE_N;
  // Comparator operators
  localparam logic [1:0] CMP_GT = 2'h0;
  localparam logic [1:0] CMP_LT = 2'h1;
  localparam logic [1:0] CMP_EQ = 2'h2;
  localparam logic [1:0] CMP_NE = 2'h3;
  // Rule operators on inputs a, b, c
  localparam logic [1:0] RULE_AND3 = 2'h0;
  localparam logic [1:0] RULE_OR3 = 2'h1;
  localparam logic [1:0] RULE_AND_OR = 2'h2;
  localparam logic [1:0] RULE_OR_AND = 2'h3;
  // Sequencer states
  typedef enum logic [0:0] {
    EAS_IDLE = 1'b0,
    EAS_RUN = 1'b1
  } eas_state_t;
endpackage

// ---- eas_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Event n true executes paired action n.
// - After an action, advance to next event.
// - Only one event evaluated at a time.
// - False event: no action, no other event.
// - After start, wait on event zero first.
// - One to twenty pairs are programmable.
// - After last pair, wrap to event zero.
// - Comparators test values against preset constants.
// - Rules combine three inputs with AND/OR/NOT.
// - Event source: status, rule or comparator.
module eas_sequencer #(
  parameter int PAIRS = eas_pkg::MAX_PAIRS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic seq_run,
  input wire logic scan_tick,
  input wire logic [4:0] num_pairs,
  input wire logic [eas_pkg::STATUS_N-1:0] status_in,
  input wire logic [eas_pkg::CMP_N*eas_pkg::VAL_W-1:0] cmp_value,
  input wire logic [eas_pkg::CMP_N*eas_pkg::VAL_W-1:0] cmp_preset,
  input wire logic [eas_pkg::CMP_N*2-1:0] cmp_op,
  input wire logic [eas_pkg::RULE_N*3*eas_pkg::SEL_W-1:0] rule_sel,
  input wire logic [eas_pkg::RULE_N*3-1:0] rule_inv,
  input wire logic [eas_pkg::RULE_N*2-1:0] rule_op,
  input wire logic [PAIRS*eas_pkg::SEL_W-1:0] event_sel,
  output logic [4:0] step_index,
  output logic action_strobe,
  output logic [4:0] action_index,
  output logic [eas_pkg::CMP_N-1:0] cmp_result,
  output logic [eas_pkg::RULE_N-1:0] rule_result
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Pick one bit of a source vector; out-of-range selects read as false
  function automatic logic pick_bit(input logic [15:0] src, input logic [3:0] sel,
                                    input int n);
    logic r;
    r = 1'b0;
    if (int'(sel) < n)
    begin
      r = src[sel];
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  eas_pkg::eas_state_t state_reg; // Running or idle
  logic [4:0] step_reg; // Current event/action pair
  logic [4:0] last_step; // Index of the last programmed pair, clamped to 0..PAIRS-1
  logic [eas_pkg::CMP_N-1:0] cmp_reg; // Registered comparator outputs
  logic [eas_pkg::RULE_N-1:0] rule_reg; // Registered rule outputs
  logic event_hit_reg; // Last evaluated event was true
  logic act_reg; // Action pulse, one enabled cycle long; held while clk_en is low
  logic [4:0] act_idx_reg; // Index of the executed action
  logic [15:0] rule_src; // Sources visible to rules
  logic [15:0] evt_src; // Sources visible to events
  logic [3:0] cur_sel; // Selector of the current event
  logic event_true; // Current event condition
  logic eval_now; // An evaluation happens this cycle

  // --------------------------------------------------------------------------
  // Source buses
  // --------------------------------------------------------------------------
  // Rules see registered comparators so no combinational loop can form
  assign rule_src = 16'(({event_hit_reg, cmp_reg, status_in}));
  assign evt_src = {rule_reg, cmp_reg, status_in};

  // Zero pairs would stall the sequencer, so it counts as one
  assign last_step = (num_pairs == 5'h00) ? 5'h00 :
                     (int'(num_pairs) > PAIRS) ? 5'(PAIRS - 1) : num_pairs - 5'h01;

  // Only the selector of the current pair is ever looked at
  assign cur_sel = event_sel[step_reg*eas_pkg::SEL_W +: eas_pkg::SEL_W];
  assign event_true = pick_bit(evt_src, cur_sel, eas_pkg::EVT_SRC_N);
  assign eval_now = clk_en && scan_tick && (state_reg == eas_pkg::EAS_RUN) && seq_run;

  // --------------------------------------------------------------------------
  // Comparators
  // --------------------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < eas_pkg::CMP_N; gc++)
    begin : g_cmp
      logic [eas_pkg::VAL_W-1:0] val;
      logic [eas_pkg::VAL_W-1:0] pre;
      assign val = cmp_value[gc*eas_pkg::VAL_W +: eas_pkg::VAL_W];
      assign pre = cmp_preset[gc*eas_pkg::VAL_W +: eas_pkg::VAL_W];
      // Registered compare against the fixed preset
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          cmp_reg[gc] <= 1'b0;
        end
        else if (clk_en)
        begin
          case (cmp_op[gc*2 +: 2])
            eas_pkg::CMP_GT: cmp_reg[gc] <= val > pre;
            eas_pkg::CMP_LT: cmp_reg[gc] <= val < pre;
            eas_pkg::CMP_EQ: cmp_reg[gc] <= val == pre;
            default: cmp_reg[gc] <= val != pre;
          endcase
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Logic rules
  // --------------------------------------------------------------------------
  genvar gr;
  generate
    for (gr = 0; gr < eas_pkg::RULE_N; gr++)
    begin : g_rule
      logic a;
      logic b;
      logic c;
      // Each input may be inverted, which supplies NOT
      assign a = pick_bit(rule_src, rule_sel[(gr*3)*4 +: 4], eas_pkg::RULE_SRC_N)
                 ^ rule_inv[gr*3];
      assign b = pick_bit(rule_src, rule_sel[(gr*3+1)*4 +: 4], eas_pkg::RULE_SRC_N)
                 ^ rule_inv[gr*3+1];
      assign c = pick_bit(rule_src, rule_sel[(gr*3+2)*4 +: 4], eas_pkg::RULE_SRC_N)
                 ^ rule_inv[gr*3+2];
      // Registered rule result
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          rule_reg[gr] <= 1'b0;
        end
        else if (clk_en)
        begin
          case (rule_op[gr*2 +: 2])
            eas_pkg::RULE_AND3: rule_reg[gr] <= a & b & c;
            eas_pkg::RULE_OR3: rule_reg[gr] <= a | b | c;
            eas_pkg::RULE_AND_OR: rule_reg[gr] <= (a & b) | c;
            default: rule_reg[gr] <= (a | b) & c;
          endcase
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Run state
  // --------------------------------------------------------------------------
  // Idle while stopped; entering run always starts at pair zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= eas_pkg::EAS_IDLE;
    end
    else if (clk_en)
    begin
      case (state_reg)
        eas_pkg::EAS_IDLE: state_reg <= seq_run ? eas_pkg::EAS_RUN : eas_pkg::EAS_IDLE;
        default: state_reg <= seq_run ? eas_pkg::EAS_RUN : eas_pkg::EAS_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Step pointer
  // --------------------------------------------------------------------------
  // Advances only on a true event; a false event leaves it parked
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      step_reg <= eas_pkg::STEP_RESET;
    end
    else if (clk_en)
    begin
      if (!seq_run || state_reg == eas_pkg::EAS_IDLE)
      begin
        step_reg <= eas_pkg::STEP_RESET;
      end
      else if (eval_now && event_true)
      begin
        if (step_reg >= last_step)
        begin
          step_reg <= eas_pkg::STEP_RESET;
        end
        else
        begin
          step_reg <= step_reg + 5'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Action output
  // --------------------------------------------------------------------------
  // Action pulse carries the same index as the event that fired
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      act_reg <= 1'b0;
      act_idx_reg <= 5'h00;
      event_hit_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      act_reg <= eval_now && event_true;
      if (eval_now)
      begin
        event_hit_reg <= event_true;
      end
      if (eval_now && event_true)
      begin
        act_idx_reg <= step_reg;
      end
    end
  end

  assign step_index = step_reg;
  assign action_strobe = act_reg;
  assign action_index = act_idx_reg;
  assign cmp_result = cmp_reg;
  assign rule_result = rule_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_fire;
    eval_now && event_true;
  endsequence

  sequence s_stall;
    eval_now && !event_true;
  endsequence

  AST_PAIR_INDEX: assert property (
    s_fire |=> action_strobe && action_index == $past(step_reg))
    else $error("Action index differs from fired event");
  AST_ADVANCE: assert property (
    (s_fire and (step_reg < last_step)) |=> step_reg == $past(step_reg) + 5'h01)
    else $error("Pointer did not advance after action");
  AST_ONE_STEP: assert property (
    clk_en && $changed(step_reg) && step_reg != 5'h00
    |-> $past(step_reg) + 5'h01 == step_reg)
    else $error("Pointer skipped an event");
  AST_FALSE_HOLD: assert property (
    (s_stall and seq_run) |=> !action_strobe && $stable(step_reg))
    else $error("False event caused activity");
  AST_START_ZERO: assert property (
    clk_en && state_reg == eas_pkg::EAS_IDLE ##1 state_reg == eas_pkg::EAS_RUN
    |-> step_reg == 5'h00)
    else $error("Run did not start at event zero");
  AST_RANGE: assert property (step_reg < 5'(PAIRS))
    else $error("Pointer beyond twenty pairs");
  AST_WRAP: assert property (
    (s_fire and (step_reg >= last_step)) |=> step_reg == 5'h00)
    else $error("No wrap after last pair");
  AST_CMP_GT: assert property (
    clk_en && cmp_op[1:0] == eas_pkg::CMP_GT
    |=> cmp_result[0] == ($past(cmp_value[15:0]) > $past(cmp_preset[15:0])))
    else $error("Comparator zero result wrong");
  // A frozen clock enable may hold an earlier pulse, so only enabled edges count
  AST_NO_TICK: assert property (clk_en && !scan_tick |=> !action_strobe)
    else $error("Action without scan tick");
  AST_STOP_ZERO: assert property (clk_en && !seq_run |=> step_reg == 5'h00 [*2])
    else $error("Stop did not clear pointer");

endmodule
`default_nettype wire

// ---- eas_sequencer_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module eas_sequencer_bench;
  // ----------------------------------------
  // Stimulus, observed outputs and tallies
  // ----------------------------------------
  logic ref_clk, rst, clk_en, seq_run, scan_tick;
  logic [4:0] num_pairs, step_index, action_index;
  logic [7:0] status_in;
  logic [63:0] cmp_value, cmp_preset;
  logic [7:0] cmp_op, rule_op;
  logic [47:0] rule_sel;
  logic [11:0] rule_inv;
  logic [79:0] event_sel;
  logic action_strobe;
  logic [3:0] cmp_result, rule_result;
  int error_cnt, n_tests;

  eas_sequencer dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .seq_run(seq_run),
    .scan_tick(scan_tick), .num_pairs(num_pairs), .status_in(status_in),
    .cmp_value(cmp_value), .cmp_preset(cmp_preset), .cmp_op(cmp_op), .rule_sel(rule_sel),
    .rule_inv(rule_inv), .rule_op(rule_op), .event_sel(event_sel), .step_index(step_index),
    .action_strobe(action_strobe), .action_index(action_index), .cmp_result(cmp_result),
    .rule_result(rule_result));

  // ----------------------------------------
  // Clock at 250 MHz
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Compare, tick and closing tasks
  // ----------------------------------------
  // Vector results, zero-extended to one width
  task chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // One scan tick; sources settle a cycle ahead so registered rules see them,
  // and the strobe is looked at in the one cycle it stands
  task tick(input logic [7:0] st, input logic en, input logic [7:0] act,
            input logic [7:0] idx, input logic [7:0] step);
    @(posedge ref_clk);
    status_in <= st;
    clk_en <= en;
    @(posedge ref_clk);
    scan_tick <= 1'b1;
    @(posedge ref_clk);
    scan_tick <= 1'b0;
    clk_en <= 1'b1;
    #1;
    chk_val({7'h00, action_strobe}, act);
    chk_val({3'h0, action_index}, idx);
    chk_val({3'h0, step_index}, step);
    @(posedge ref_clk);
    #1;
    chk_val({7'h00, action_strobe}, 8'h00);
  endtask

  task report_and_stop;
    $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Run start: the run state lands one edge after seq_run rises
  task start_run;
    @(posedge ref_clk);
    seq_run <= 1'b1;
    @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Comparator k uses operator k on the same value pair
  task sc_compare(input logic [15:0] v, input logic [7:0] exp);
    @(posedge ref_clk);
    cmp_value <= {4{v}};
    repeat (2) @(posedge ref_clk);
    #1;
    chk_val({4'h0, cmp_result}, exp);
  endtask

  // Rule r uses operator r on status bits 0, 1 and 2
  task sc_rule(input logic [2:0] s, input logic [11:0] inv, input logic [7:0] exp);
    @(posedge ref_clk);
    status_in <= {5'h00, s};
    rule_inv <= inv;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_val({4'h0, rule_result}, exp);
  endtask

  // Five pairs: status 0, 1, 2, comparator 0, rule 0
  task sc_sequence;
    // Earlier scenarios leave inverted rule inputs and set status bits behind
    @(posedge ref_clk);
    status_in <= 8'h00;
    rule_inv <= 12'h000;
    start_run();
    tick(8'h00, 1'b1, 8'h00, 8'h00, 8'h00);
    tick(8'hfe, 1'b1, 8'h00, 8'h00, 8'h00);
    tick(8'h01, 1'b1, 8'h01, 8'h00, 8'h01);
    tick(8'h00, 1'b1, 8'h00, 8'h00, 8'h01);
    tick(8'h02, 1'b0, 8'h00, 8'h00, 8'h01);
    tick(8'h02, 1'b1, 8'h01, 8'h01, 8'h02);
    tick(8'h04, 1'b1, 8'h01, 8'h02, 8'h03);
    tick(8'h00, 1'b1, 8'h01, 8'h03, 8'h04);
    tick(8'h07, 1'b1, 8'h01, 8'h04, 8'h00);
  endtask

  // Stop mid-sequence, then a clamped single-pair run
  task sc_stop_single;
    tick(8'h01, 1'b1, 8'h01, 8'h00, 8'h01);
    @(posedge ref_clk);
    seq_run <= 1'b0;
    num_pairs <= 5'h00;
    @(posedge ref_clk);
    #1;
    chk_val({3'h0, step_index}, 8'h00);
    start_run();
    tick(8'h01, 1'b1, 8'h01, 8'h00, 8'h00);
    tick(8'h01, 1'b1, 8'h01, 8'h00, 8'h00);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    error_cnt = 0;
    n_tests = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    seq_run = 1'b0;
    scan_tick = 1'b0;
    num_pairs = 5'h05;
    status_in = 8'h00;
    cmp_value = 64'h0;
    cmp_preset = {4{16'h0003}};
    cmp_op = {eas_pkg::CMP_NE, eas_pkg::CMP_EQ, eas_pkg::CMP_LT, eas_pkg::CMP_GT};
    rule_sel = {4{12'h210}};
    rule_inv = 12'h000;
    rule_op = {eas_pkg::RULE_OR_AND, eas_pkg::RULE_AND_OR, eas_pkg::RULE_OR3, eas_pkg::RULE_AND3};
    event_sel = 80'hc8210;
    repeat (4) @(posedge ref_clk);
    chk_val({2'h0, action_strobe, step_index}, 8'h00);
    rst <= 1'b0;
    sc_compare(16'h0005, 8'h09);
    sc_compare(16'h0003, 8'h04);
    sc_compare(16'h0002, 8'h0a);
    sc_rule(3'h3, 12'h000, 8'h06);
    sc_rule(3'h5, 12'h000, 8'h0e);
    sc_rule(3'h0, 12'hfff, 8'h0f);
    sc_rule(3'h7, 12'hfff, 8'h00);
    sc_compare(16'h0005, 8'h09);
    sc_sequence();
    sc_stop_single();
    report_and_stop();
  end

  // Whole run needs about 83 cycles; a hang is cut far beyond that
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
